/* core/zrt_defs.svh */
`ifndef ZRT_DEFS_SVH
`define ZRT_DEFS_SVH
`define ZRT_DLY_W      8
`define ZRT_NUM_LOC    4
`define ZRT_NUM_BUSY   4
`define ZRT_NUM_PIN    14
`define ZRT_WORD_W     32
`define ZRT_CLK_NS     40
`define ZRT_PULSE_NS   100
`define ZRT_PULSE_CYC  ((`ZRT_PULSE_NS + `ZRT_CLK_NS - 1) / `ZRT_CLK_NS)
`define ZRT_PCNT_W     4
`define ZRT_SEL_DIGI   2'h0
`define ZRT_SEL_TDC    2'h1
`define ZRT_SEL_SCAL   2'h2
`define ZRT_CYC_VME64  2'h2
`define ZRT_CYC_2ESST  2'h3
`define ZRT_PIN_NEUTRON_A 0
`define ZRT_PIN_NEUTRON_C 1
`define ZRT_PIN_ZPA    2
`define ZRT_PIN_ZPC    3
`define ZRT_PIN_EM1    4
`define ZRT_PIN_EM2    5
`define ZRT_PIN_LOC    6
`define ZRT_PIN_BUSY   10
`endif

/* core/zrt_pkg.sv */
`default_nettype none
package zrt_pkg;
    typedef enum logic [5:0] {
        ZRT_IDLE = 6'h01,
        ZRT_DIGI = 6'h02,
        ZRT_TDC  = 6'h04,
        ZRT_SCAL = 6'h08,
        ZRT_FILL = 6'h10,
        ZRT_DONE = 6'h20
    } zrt_state_t;
    typedef enum logic [2:0] {
        ZRT_MODE_NORMAL = 3'h0,
        ZRT_MODE_PED    = 3'h1,
        ZRT_MODE_LASER  = 3'h2,
        ZRT_MODE_COSMIC = 3'h3,
        ZRT_MODE_ENERGY = 3'h4,
        ZRT_MODE_L1CAL  = 3'h5
    } zrt_mode_t;
endpackage
`default_nettype wire

/* core/zrt_readout_trigger.sv */
// Contract
// - Take trigger from upstream link and fan it out on NIM and ECL outputs.
// - Delay fanned-out trigger by an adjustable count before it leaves.
// - A physics trigger acquires one event from digitizers and TDC.
// - A calibration trigger additionally reads the scaler modules.
// - Collect each event from the modules, then send it upstream.
// - OR the front-panel busy inputs into one upstream busy.
// - Read modules with fast block-transfer cycles, VME64 or 2eSST.
// - One link upstream: trigger in, busy and event data out.
// - Upstream path carries full VME readout bandwidth without loss.
// - Support pedestal, laser, cosmic, energy and level-1 calibration modes.
// - Local trigger inputs, each with its own delay line.
// - An extra trigger output fires the laser pulses in laser mode.
// - Local trigger dispatches only if front-end ready and link operational.
// - Level-0 output is coincidence of both neutron calorimeter towers.
// - Level-1 outputs combine six calorimeters, synchronized, sent on LVDS.
`timescale 1ns/1ns
`default_nettype none
`include "zrt_defs.svh"
module zrt_readout_trigger (
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 link_up,
    input  wire logic                                 link_trig_valid,
    input  wire logic                                 link_trig_calib,
    input  wire logic [`ZRT_DLY_W-1:0]                trig_delay,
    input  wire logic [`ZRT_NUM_LOC*`ZRT_DLY_W-1:0]   local_delay,
    input  wire zrt_pkg::zrt_mode_t                   run_mode,
    input  wire logic                                 use_2esst,
    input  wire logic [`ZRT_NUM_PIN-1:0]              panel_in,
    input  wire logic                                 vme_valid,
    input  wire logic [`ZRT_WORD_W-1:0]               vme_data,
    input  wire logic                                 vme_last,
    input  wire logic                                 up_ready,
    output logic                                      nim_trig_r,
    output logic                                      ecl_trig_r,
    output logic                                      laser_out_r,
    output logic                                      local_drop_r,
    output logic                                      up_busy_r,
    output logic                                      vme_req_r,
    output logic [1:0]                                vme_sel_r,
    output logic [1:0]                                vme_cycle_r,
    output logic                                      vme_ready_r,
    output logic                                      up_valid_r,
    output logic [`ZRT_WORD_W-1:0]                    up_data_r,
    output logic                                      up_last_r,
    output logic                                      first_level_trigger_r,
    output logic [3:0]                                second_level_trigger_r
);
    import zrt_pkg::*;

    // Three-stage synchroniser; stage two feeds logic, stage three only the local-trigger edge detect
    logic [`ZRT_NUM_PIN-1:0] pin_s1_r;
    logic [`ZRT_NUM_PIN-1:0] pin_s2_r;
    logic [`ZRT_NUM_PIN-1:0] pin_s3_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= panel_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    logic                     neutron_calorimeter_side_a;
    logic                     neutron_calorimeter_side_c;
    logic                     busy_or;
    logic [`ZRT_NUM_LOC-1:0]  loc_edge;
    assign neutron_calorimeter_side_a = pin_s2_r[`ZRT_PIN_NEUTRON_A];
    assign neutron_calorimeter_side_c = pin_s2_r[`ZRT_PIN_NEUTRON_C];
    assign busy_or  = |pin_s2_r[`ZRT_PIN_BUSY +: `ZRT_NUM_BUSY];
    assign loc_edge = pin_s2_r[`ZRT_PIN_LOC +: `ZRT_NUM_LOC]
                    & ~pin_s3_r[`ZRT_PIN_LOC +: `ZRT_NUM_LOC];

    // Busy and calorimeter trigger outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            up_busy_r              <= 1'b0;
            first_level_trigger_r  <= 1'b0;
            second_level_trigger_r <= 4'h0;
        end else begin
            up_busy_r              <= busy_or;
            first_level_trigger_r  <= neutron_calorimeter_side_a
                                    & neutron_calorimeter_side_c;
            second_level_trigger_r <= {pin_s2_r[`ZRT_PIN_EM1] | pin_s2_r[`ZRT_PIN_EM2],
                                       pin_s2_r[`ZRT_PIN_ZPA] & pin_s2_r[`ZRT_PIN_ZPC],
                                       neutron_calorimeter_side_a | neutron_calorimeter_side_c,
                                       neutron_calorimeter_side_a & neutron_calorimeter_side_c};
        end
    end

    // Per-input delay lines for local triggers
    logic [`ZRT_NUM_LOC-1:0] loc_fire;
    genvar gi;
    generate
        for (gi = 0; gi < `ZRT_NUM_LOC; gi = gi + 1) begin : g_loc
            logic [`ZRT_DLY_W-1:0] cnt_r;
            logic                  run_r;
            assign loc_fire[gi] = run_r && (cnt_r == '0);
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    cnt_r <= '0;
                    run_r <= 1'b0;
                end else if (loc_edge[gi] && !run_r) begin
                    cnt_r <= local_delay[gi*`ZRT_DLY_W +: `ZRT_DLY_W];
                    run_r <= 1'b1;
                end else if (run_r) begin
                    cnt_r <= cnt_r - 1'b1;
                    run_r <= (cnt_r != '0);
                end
            end
        end
    endgenerate

    zrt_state_t              state_r;
    logic                    pend_r;
    logic                    pend_calib_r;
    logic [`ZRT_DLY_W-1:0]   dly_cnt_r;
    logic [`ZRT_PCNT_W-1:0]  pulse_cnt_r;
    logic                    ev_calib_r;
    logic                    self_mode;
    logic                    self_src;
    logic                    fe_ready;
    logic                    link_take;
    logic                    link_fire;
    logic                    self_take;
    logic                    start;

    assign self_mode = (run_mode != ZRT_MODE_NORMAL);
    // Energy and level-1 calibration also trigger on the calorimeter combinations
    assign self_src  = (|loc_fire)
                     || (run_mode == ZRT_MODE_ENERGY && first_level_trigger_r)
                     || (run_mode == ZRT_MODE_L1CAL && (|second_level_trigger_r));
    assign fe_ready  = !busy_or && (state_r == ZRT_IDLE) && !pend_r
                     && (pulse_cnt_r == '0);
    // A link trigger arriving during a readout is refused; up_busy_r does not signal it
    assign link_take = link_trig_valid && (state_r == ZRT_IDLE) && !pend_r
                     && (pulse_cnt_r == '0);
    assign link_fire = pend_r && (dly_cnt_r == '0);
    assign self_take = self_mode && self_src && fe_ready && link_up
                     && !link_trig_valid;
    assign start     = link_fire || self_take;

    // Link trigger delay
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_r       <= 1'b0;
            pend_calib_r <= 1'b0;
            dly_cnt_r    <= '0;
        end else if (link_take) begin
            pend_r       <= 1'b1;
            pend_calib_r <= link_trig_calib;
            dly_cnt_r    <= trig_delay;
        end else if (pend_r) begin
            dly_cnt_r    <= dly_cnt_r - 1'b1;
            pend_r       <= (dly_cnt_r != '0);
        end
    end

    // Fan-out pulse; self triggers never drop out once accepted
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pulse_cnt_r  <= '0;
            nim_trig_r   <= 1'b0;
            ecl_trig_r   <= 1'b0;
            laser_out_r  <= 1'b0;
            local_drop_r <= 1'b0;
        end else begin
            if (start) begin
                pulse_cnt_r <= `ZRT_PCNT_W'(`ZRT_PULSE_CYC);
            end else if (pulse_cnt_r != '0) begin
                pulse_cnt_r <= pulse_cnt_r - 1'b1;
            end
            nim_trig_r   <= start || (pulse_cnt_r > `ZRT_PCNT_W'(1));
            ecl_trig_r   <= start || (pulse_cnt_r > `ZRT_PCNT_W'(1));
            laser_out_r  <= (self_take && run_mode == ZRT_MODE_LASER)
                         || (laser_out_r && pulse_cnt_r > `ZRT_PCNT_W'(1));
            local_drop_r <= self_mode && self_src && !self_take;
        end
    end

    // Two-entry skid buffer between VME and the link; stalls the VME side
    logic                   push;
    logic                   pop;
    logic                   spare_v_r;
    logic [`ZRT_WORD_W:0]   spare_r;
    logic                   spare_v_nxt;
    assign push = vme_valid && vme_ready_r && vme_req_r;
    assign pop  = up_valid_r && up_ready;
    always_comb begin
        spare_v_nxt = spare_v_r;
        if (spare_v_r && pop) begin
            spare_v_nxt = 1'b0;
        end else if (!spare_v_r && push && up_valid_r && !pop) begin
            spare_v_nxt = 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            spare_v_r   <= 1'b0;
            spare_r     <= '0;
            up_valid_r  <= 1'b0;
            up_data_r   <= '0;
            up_last_r   <= 1'b0;
            vme_ready_r <= 1'b0;
        end else begin
            spare_v_r   <= spare_v_nxt;
            vme_ready_r <= !spare_v_nxt;
            if (spare_v_r) begin
                if (pop) begin
                    {up_last_r, up_data_r} <= spare_r;
                end
            end else if (!up_valid_r || pop) begin
                up_valid_r <= push;
                if (push) begin
                    {up_last_r, up_data_r} <= {vme_last && state_r == ZRT_FILL, vme_data};
                end
            end else if (push) begin
                spare_r <= {vme_last && state_r == ZRT_FILL, vme_data};
            end
        end
    end

    // Readout sequence: digitizers, TDC, scalers on calibration
    logic last_in;
    assign last_in = push && vme_last;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r     <= ZRT_IDLE;
            ev_calib_r  <= 1'b0;
            vme_req_r   <= 1'b0;
            vme_sel_r   <= `ZRT_SEL_DIGI;
            vme_cycle_r <= `ZRT_CYC_VME64;
        end else begin
            case (state_r)
                ZRT_IDLE: begin
                    if (start) begin
                        state_r     <= ZRT_DIGI;
                        ev_calib_r  <= link_fire ? pend_calib_r : 1'b1;
                        vme_req_r   <= 1'b1;
                        vme_sel_r   <= `ZRT_SEL_DIGI;
                        vme_cycle_r <= use_2esst ? `ZRT_CYC_2ESST : `ZRT_CYC_VME64;
                    end
                end
                ZRT_DIGI: begin
                    if (last_in) begin
                        state_r   <= ev_calib_r ? ZRT_TDC : ZRT_FILL;
                        vme_sel_r <= `ZRT_SEL_TDC;
                    end
                end
                ZRT_TDC: begin
                    if (last_in) begin
                        state_r   <= ZRT_FILL;
                        vme_sel_r <= `ZRT_SEL_SCAL;
                    end
                end
                ZRT_FILL: begin
                    if (last_in) begin
                        state_r   <= ZRT_DONE;
                        vme_req_r <= 1'b0;
                    end
                end
                ZRT_DONE: begin
                    // Wait until the event has fully left for the link
                    if (!up_valid_r && !spare_v_r) begin
                        state_r <= ZRT_IDLE;
                    end
                end
                default: begin
                    state_r   <= ZRT_IDLE;
                    vme_req_r <= 1'b0;
                end
            endcase
        end
    end

    property p_busy_or;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> up_busy_r == $past(busy_or);
    endproperty
    a_busy_or: assert property (p_busy_or) else $error("busy not OR of inputs");

    property p_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(nim_trig_r) |-> nim_trig_r[*3] ##1 !nim_trig_r;
    endproperty
    a_pulse: assert property (p_pulse) else $error("fan-out pulse width wrong");

    property p_ecl;
        @(posedge ref_clk) disable iff (!rst_n)
        ecl_trig_r == nim_trig_r;
    endproperty
    a_ecl: assert property (p_ecl) else $error("ECL and NIM differ");

    property p_delay0;
        @(posedge ref_clk) disable iff (!rst_n)
        (link_take && trig_delay == 8'h00) |-> ##1 !nim_trig_r ##1 nim_trig_r;
    endproperty
    a_delay0: assert property (p_delay0) else $error("trigger delay wrong");

    property p_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        // A link trigger firing in the same cycle may still start a readout
        (self_mode && self_src && (!link_up || busy_or) && state_r == ZRT_IDLE
            && !link_fire) |=> local_drop_r && state_r == ZRT_IDLE;
    endproperty
    a_drop: assert property (p_drop) else $error("local trigger not dropped");

    property p_self_ok;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == ZRT_IDLE && !link_fire) ##1 state_r == ZRT_DIGI
            |-> $past(link_up) && !$past(busy_or);
    endproperty
    a_self_ok: assert property (p_self_ok) else $error("dispatch while not ready");

    property p_scal;
        @(posedge ref_clk) disable iff (!rst_n)
        (vme_req_r && vme_sel_r == `ZRT_SEL_SCAL) |-> ev_calib_r;
    endproperty
    a_scal: assert property (p_scal) else $error("scalers read on physics");

    property p_order;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_r == ZRT_DIGI && last_in) |=> vme_sel_r == `ZRT_SEL_TDC;
    endproperty
    a_order: assert property (p_order) else $error("TDC not read after digitizers");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (up_valid_r && !up_ready) |=> up_valid_r && $stable(up_data_r);
    endproperty
    a_hold: assert property (p_hold) else $error("upstream word lost in stall");

    property p_coinc;
        @(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> first_level_trigger_r
                 == ($past(neutron_calorimeter_side_a) && $past(neutron_calorimeter_side_c));
    endproperty
    a_coinc: assert property (p_coinc) else $error("coincidence wrong");

    property p_laser;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(laser_out_r) |-> nim_trig_r && $past(run_mode) == ZRT_MODE_LASER;
    endproperty
    a_laser: assert property (p_laser) else $error("laser fired outside laser mode");

    c_calib: cover property (@(posedge ref_clk) disable iff (!rst_n)
        vme_req_r && vme_sel_r == `ZRT_SEL_SCAL && last_in);
    c_drop: cover property (@(posedge ref_clk) disable iff (!rst_n) local_drop_r);
    c_full: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !vme_ready_r && vme_req_r);
    c_laser: cover property (@(posedge ref_clk) disable iff (!rst_n) laser_out_r);
endmodule
`default_nettype wire

/* tb/zrt_conc_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "zrt_defs.svh"
module zrt_conc_model (
    input  wire logic                   ref_clk,
    input  wire logic                   stall_en,
    input  wire logic                   up_valid_r,
    input  wire logic [`ZRT_WORD_W-1:0] up_data_r,
    input  wire logic                   up_last_r,
    output var  logic                   link_up,
    output var  logic                   link_trig_valid,
    output var  logic                   link_trig_calib,
    output var  logic                   up_ready
);
    logic [`ZRT_WORD_W:0] rx_q[$];
    logic [2:0]           ph;
    initial begin
        link_up = 1'b0;
        link_trig_valid = 1'b0;
        link_trig_calib = 1'b0;
        up_ready = 1'b0;
        ph = 3'h0;
    end
    // Ready one cycle in eight when stalling, long enough to fill the design's buffer
    always @(negedge ref_clk) begin
        ph = ph + 3'h1;
        up_ready = !stall_en || (ph == 3'h7);
        if (up_valid_r && up_ready) begin
            rx_q.push_back({up_last_r, up_data_r});
        end
    end
    task automatic send_trig(input logic calib);
        @(negedge ref_clk);
        link_trig_valid = 1'b1;
        link_trig_calib = calib;
        @(negedge ref_clk);
        link_trig_valid = 1'b0;
        link_trig_calib = !calib;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "zrt_defs.svh"
module tb;
    import zrt_pkg::*;
    typedef struct packed {
        logic [13:0] pin;
        logic        fl;
        logic [3:0]  sl;
        logic        busy;
    } zrt_row_t;
    logic ref_clk, rst_n, link_up, link_trig_valid, link_trig_calib, use_2esst, stall_en;
    logic [7:0]  trig_delay;
    logic [31:0] local_delay, vme_data, up_data_r;
    zrt_mode_t   run_mode;
    logic [13:0] panel_in;
    logic vme_valid, vme_last, up_ready, nim_trig_r, ecl_trig_r, laser_out_r, local_drop_r;
    logic up_busy_r, vme_req_r, vme_ready_r, up_valid_r, up_last_r, first_level_trigger_r;
    logic [1:0]  vme_sel_r, vme_cycle_r;
    logic [3:0]  second_level_trigger_r;
    int          error_cnt, num_checks, k;
    logic        saw_full;
    zrt_row_t    rows [8] = '{{14'h0000, 1'b0, 4'h0, 1'b0}, {14'h0001, 1'b0, 4'h2, 1'b0},
        {14'h0003, 1'b1, 4'h3, 1'b0}, {14'h000C, 1'b0, 4'h4, 1'b0},
        {14'h0010, 1'b0, 4'h8, 1'b0}, {14'h0020, 1'b0, 4'h8, 1'b0},
        {14'h0400, 1'b0, 4'h0, 1'b1}, {14'h2000, 1'b0, 4'h0, 1'b1}};
    zrt_readout_trigger u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_up(link_up),
        .link_trig_valid(link_trig_valid), .link_trig_calib(link_trig_calib),
        .trig_delay(trig_delay), .local_delay(local_delay), .run_mode(run_mode),
        .use_2esst(use_2esst), .panel_in(panel_in), .vme_valid(vme_valid),
        .vme_data(vme_data), .vme_last(vme_last), .up_ready(up_ready),
        .nim_trig_r(nim_trig_r), .ecl_trig_r(ecl_trig_r), .laser_out_r(laser_out_r),
        .local_drop_r(local_drop_r), .up_busy_r(up_busy_r), .vme_req_r(vme_req_r),
        .vme_sel_r(vme_sel_r), .vme_cycle_r(vme_cycle_r), .vme_ready_r(vme_ready_r),
        .up_valid_r(up_valid_r), .up_data_r(up_data_r), .up_last_r(up_last_r),
        .first_level_trigger_r(first_level_trigger_r),
        .second_level_trigger_r(second_level_trigger_r));
    zrt_conc_model u_conc (.ref_clk(ref_clk), .stall_en(stall_en), .up_valid_r(up_valid_r),
        .up_data_r(up_data_r), .up_last_r(up_last_r), .link_up(link_up),
        .link_trig_valid(link_trig_valid), .link_trig_calib(link_trig_calib),
        .up_ready(up_ready));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic chk_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_vec(input string nm, input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_out(input logic drop, input int lim, output int n);
        n = 0;
        while ((drop ? local_drop_r : nim_trig_r) !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic chk_pulse(input logic laser);
        for (int i = 0; i < 3; i++) begin
            chk_bit("nim", 1'b1, nim_trig_r);
            chk_bit("ecl", 1'b1, ecl_trig_r);
            chk_bit("laser", laser, laser_out_r);
            @(negedge ref_clk);
        end
        chk_bit("nim_end", 1'b0, nim_trig_r);
    endtask
    task automatic feed(input logic [1:0] sel, input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            vme_valid = 1'b1;
            vme_data = {16'hA5A5, 6'h00, sel, i[7:0]};
            vme_last = (i == n - 1);
            t = 0;
            while (!(vme_ready_r && vme_req_r) && t < 200) begin
                saw_full |= vme_req_r;
                @(negedge ref_clk);
                t++;
            end
            chk_vec("vme_sel", {31'h0, sel}, {31'h0, vme_sel_r});
            @(negedge ref_clk);
        end
    endtask
    task automatic readout(input logic calib);
        int t, nb, j;
        nb = calib ? 3 : 2;
        for (int b = 0; b < nb; b++) begin
            feed(b[1:0], (b == 0) ? 3 : 2);
        end
        // Released only after the final block; the next block raises valid at once
        vme_valid = 1'b0;
        vme_last = 1'b0;
        vme_data = ~vme_data;
        t = 0;
        while (u_conc.rx_q.size() < 2 * nb + 1 && t < 400) begin
            @(negedge ref_clk);
            t++;
        end
        j = 0;
        for (int b = 0; b < nb; b++) begin
            for (int i = 0; i < ((b == 0) ? 3 : 2); i++) begin
                j++;
                chk_vec("up_word", {j == 2 * nb + 1, 16'hA5A5, 6'h00, b[1:0], i[7:0]},
                    (u_conc.rx_q.size() > 0) ? u_conc.rx_q.pop_front() : 'x);
            end
        end
        chk_bit("vme_req_end", 1'b0, vme_req_r);
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic run_event(input logic calib, input logic [7:0] d, input logic esst);
        trig_delay = d;
        use_2esst = esst;
        u_conc.send_trig(calib);
        wait_out(1'b0, 300, k);
        // Counted from the falling edge after the taking edge
        chk_vec("nim_delay", 33'(d) + 33'd1, 33'(k));
        chk_pulse(1'b0);
        chk_vec("vme_cycle", 33'(esst ? `ZRT_CYC_2ESST : `ZRT_CYC_VME64),
            33'(vme_cycle_r));
        u_conc.send_trig(1'b0);
        wait_out(1'b0, 8, k);
        chk_bit("nim_refused", 1'b0, nim_trig_r);
        readout(calib);
        $display("test link event calib=%0b done", calib);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {rst_n, trig_delay, local_delay, use_2esst, panel_in, saw_full} = '0;
        {vme_valid, vme_data, vme_last, stall_en} = '0;
        run_mode = ZRT_MODE_NORMAL;
        repeat (5) @(negedge ref_clk);
        chk_bit("nim_rst", 1'b0, nim_trig_r);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk_bit("up_valid_rst", 1'b0, up_valid_r);
        chk_vec("cycle_rst", 33'(`ZRT_CYC_VME64), 33'(vme_cycle_r));
        $display("test reset done");
        u_conc.link_up = 1'b1;
        foreach (rows[i]) begin
            panel_in = rows[i].pin;
            repeat (6) @(negedge ref_clk);
            chk_bit("first_level", rows[i].fl, first_level_trigger_r);
            chk_vec("second_level", 33'(rows[i].sl), 33'(second_level_trigger_r));
            chk_bit("up_busy", rows[i].busy, up_busy_r);
        end
        panel_in = '0;
        $display("test level outputs and busy done");
        stall_en = 1'b1;
        run_event(1'b0, 8'h05, 1'b0);
        chk_bit("buffer_full_seen", 1'b1, saw_full);
        stall_en = 1'b0;
        run_event(1'b1, 8'h00, 1'b1);
        for (int m = 1; m <= 5; m++) begin
            run_mode = zrt_mode_t'(m[2:0]);
            // Cosmic mode uses local input 1 with its own delay of 4
            local_delay = (m == 3) ? 32'h0000_0400 : 32'h0000_0000;
            panel_in = (m == 4) ? 14'h0003 : (m == 5) ? 14'h0010
                     : (m == 3) ? 14'h0080 : 14'h0040;
            wait_out(1'b0, 40, k);
            panel_in = '0;
            chk_bit("self_fire", 1'b1, nim_trig_r);
            chk_vec("self_latency", (m == 3) ? 33'd8 : 33'd4, 33'(k));
            chk_pulse(m == 2);
            readout(1'b1);
            run_mode = ZRT_MODE_NORMAL;
            repeat (6) @(negedge ref_clk);
            $display("test self trigger mode %0d done", m);
        end
        run_mode = ZRT_MODE_COSMIC;
        for (int c = 0; c < 2; c++) begin
            panel_in = (c == 0) ? 14'h0800 : 14'h0000;
            u_conc.link_up = (c == 0);
            repeat (6) @(negedge ref_clk);
            panel_in[6] = 1'b1;
            wait_out(1'b1, 20, k);
            chk_bit("drop", 1'b1, local_drop_r);
            chk_bit("drop_no_nim", 1'b0, nim_trig_r);
            repeat (10) @(negedge ref_clk);
            chk_vec("drop_no_data", 33'd0, 33'(u_conc.rx_q.size()));
            panel_in = '0;
            $display("test discard case %0d done", c);
        end
        finish_test();
    end
endmodule
`default_nettype wire
